// ===== rtl/espc_defs.vh
`ifndef ESPC_DEFS_VH
`define ESPC_DEFS_VH
`define ESPC_OFF_CTRL_B 5'h00
`define ESPC_OFF_HOLD_0 5'h04
`define ESPC_OFF_HOLD_1 5'h08
`define ESPC_OFF_HOLD_2 5'h0C
`define ESPC_OFF_SLOT_SKIP 5'h10
`define ESPC_OFF_RX_DATA 5'h14
`define ESPC_OFF_STATUS 5'h18
`define ESPC_OFF_SOFT_RESET 5'h1C
`define ESPC_BIT_RX_ON 17
`define ESPC_BIT_TX0_ON 16
`define ESPC_BIT_TX1_ON 15
`define ESPC_BIT_TX2_ON 14
`define ESPC_BIT_NETWORK 13
`define ESPC_BIT_SHARED 12
`define ESPC_BIT_EDGE 11
`define ESPC_BIT_FSPOL 10
`define ESPC_BIT_FLAG_0 0
`define ESPC_BIT_FLAG_1 1
`define ESPC_CTRL_B_RESET 24'h000000
`define ESPC_CTRL_B_W 24
`define ESPC_ST_TX_EMPTY 0
`define ESPC_ST_RX_FULL 1
`define ESPC_WORD_LEN 8
`define ESPC_FRAME_SLOTS 4
`endif

// ===== rtl/espc_serial_ctrl.v
// Behaviour
// - receive enable clear blocks new words; a word in progress still lands in receive data
// - receive only while receive enable is set, normal or network
// - network: receive enable toggled off disables receiver until the slot after next frame start
// - frame sync generation ignores receive enable
// - tx0 enable loads shift register 0, sync or async; active for frame on sync
// - tx0 disabled: finish current word, then data pin released, holding data dropped
// - holding write while disabled clears empty flag but never reaches shifter
// - tx1 enable works only with shared timing; active for frame on sync
// - tx1 clear at frame start: aux pin 0 becomes output flag for that frame
// - tx2 enable works only with shared timing; active for frame on sync
// - tx2 clear at frame start: aux pin 1 becomes output flag for that frame
// - frame sync runs regardless of transmitter enables; flags regardless of tx0 enable
// - network select bit: 0 normal, 1 network framing
// - normal: one word per frame in first slot; network: word every slot
// - shared timing clear: separate rx clock and sync; set: common ones
// - several transmitters only with shared timing; async runs tx0 alone
// - edge select 0: drive on rising, sample on falling; 1 the reverse
// - frame pulse polarity 0: start on rising sync; 1 on falling sync
// - control register b cleared by hardware reset and soft reset command
// - writing all enabled holding registers or slot skip clears empty flag
//
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/10ps
`include "espc_defs.vh"
module espc_serial_ctrl (
	input wire clk,
	input wire rstn,
	input wire [4:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	input wire tx_bit_clk,
	input wire rx_bit_clk,
	input wire rx_frame_pin,
	input wire serial_rx_pin,
	output reg frame_pulse_out,
	output reg serial_tx_pin_o,
	output reg serial_tx_pin_oe,
	output reg aux_pin_0_o,
	output reg aux_pin_0_oe,
	output reg aux_pin_1_o,
	output reg aux_pin_1_oe
);
	localparam W = `ESPC_WORD_LEN;
	localparam integer POS_LAST_I = W - 1;
	localparam integer SLOT_LAST_I = `ESPC_FRAME_SLOTS - 1;
	// counters are sized for the fixed word and frame lengths only
	localparam [2:0] POS_LAST = POS_LAST_I[2:0];
	localparam [1:0] SLOT_LAST = SLOT_LAST_I[1:0];

	reg soft_rst;
	wire rst = ~rstn | soft_rst;
	reg [`ESPC_CTRL_B_W-1:0] serial_ctrl_b;
	wire rx_on = serial_ctrl_b[`ESPC_BIT_RX_ON];
	wire network_select = serial_ctrl_b[`ESPC_BIT_NETWORK];
	wire shared_timing_select = serial_ctrl_b[`ESPC_BIT_SHARED];
	wire bit_clock_edge_select = serial_ctrl_b[`ESPC_BIT_EDGE];
	wire frame_pulse_polarity = serial_ctrl_b[`ESPC_BIT_FSPOL];
	wire [2:0] tx_on = {serial_ctrl_b[`ESPC_BIT_TX2_ON], serial_ctrl_b[`ESPC_BIT_TX1_ON],
		serial_ctrl_b[`ESPC_BIT_TX0_ON]};
	wire [2:0] flag_bits = {serial_ctrl_b[`ESPC_BIT_FLAG_1], serial_ctrl_b[`ESPC_BIT_FLAG_0], 1'b0};
	// tx1 and tx2 are dead without shared timing
	wire [2:0] tx_en = {tx_on[2] & shared_timing_select, tx_on[1] & shared_timing_select, tx_on[0]};

	// pins: two flops, then a third stage used only for edge finding
	reg [3:0] pin_s1;
	reg [3:0] pin_s2;
	reg [3:0] pin_s3;
	always @(posedge clk) begin
		if (!rstn) begin
			pin_s1 <= 4'h0;
			pin_s2 <= 4'h0;
			pin_s3 <= 4'h0;
		end else begin
			pin_s1 <= {serial_rx_pin, rx_frame_pin, rx_bit_clk, tx_bit_clk};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end
	wire tx_rise = pin_s2[0] & ~pin_s3[0];
	wire tx_fall = ~pin_s2[0] & pin_s3[0];
	wire rx_clk_l = shared_timing_select ? pin_s2[0] : pin_s2[1];
	wire rx_clk_p = shared_timing_select ? pin_s3[0] : pin_s3[1];
	wire drive_edge = bit_clock_edge_select ? tx_fall : tx_rise;
	wire sample_edge = bit_clock_edge_select ? (rx_clk_l & ~rx_clk_p) : (~rx_clk_l & rx_clk_p);

	// bus decode; the access lands on the edge where waitrequest is seen low
	wire acc = ~avs_waitrequest;
	wire do_wr = acc & avs_write;
	wire do_rd = acc & avs_read;
	wire [2:0] hold_wr;
	assign hold_wr[0] = do_wr & (avs_address == `ESPC_OFF_HOLD_0) & avs_byteenable[0];
	assign hold_wr[1] = do_wr & (avs_address == `ESPC_OFF_HOLD_1) & avs_byteenable[0];
	assign hold_wr[2] = do_wr & (avs_address == `ESPC_OFF_HOLD_2) & avs_byteenable[0];
	wire skip_wr = do_wr & (avs_address == `ESPC_OFF_SLOT_SKIP);
	wire rxd_rd = do_rd & (avs_address == `ESPC_OFF_RX_DATA);

	reg tx_empty_flag;
	reg rx_full;
	reg [W-1:0] rx_data;
	reg [W-1:0] next_readdata_lo;
	reg [31:0] next_readdata;
	always @* begin
		next_readdata_lo = {W{1'b0}};
		next_readdata = 32'h00000000;
		case (avs_address)
			`ESPC_OFF_CTRL_B: next_readdata = {8'h00, serial_ctrl_b};
			`ESPC_OFF_RX_DATA: next_readdata = {24'h000000, rx_data};
			`ESPC_OFF_STATUS: next_readdata = {30'h00000000, rx_full, tx_empty_flag};
			default: next_readdata = {24'h000000, next_readdata_lo};
		endcase
	end

	// one wait state per access, then released for a cycle
	always @(posedge clk) begin
		if (!rstn) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
		end else begin
			if ((avs_read | avs_write) & avs_waitrequest) begin
				avs_waitrequest <= 1'b0;
				avs_readdata <= next_readdata;
			end else begin
				avs_waitrequest <= 1'b1;
			end
		end
	end

	// soft reset lasts one cycle and clears everything but the bus slave and the pin synchronizer flops
	always @(posedge clk) begin
		if (!rstn)
			soft_rst <= 1'b0;
		else
			soft_rst <= do_wr & (avs_address == `ESPC_OFF_SOFT_RESET) & avs_writedata[0];
	end

	always @(posedge clk) begin
		if (rst) begin
			serial_ctrl_b <= `ESPC_CTRL_B_RESET;
		end else if (do_wr && avs_address == `ESPC_OFF_CTRL_B) begin
			if (avs_byteenable[0])
				serial_ctrl_b[7:0] <= avs_writedata[7:0];
			if (avs_byteenable[1])
				serial_ctrl_b[15:8] <= avs_writedata[15:8];
			if (avs_byteenable[2])
				serial_ctrl_b[23:16] <= avs_writedata[23:16];
		end
	end

	// frame timing runs off the tx bit clock whatever the enables say
	reg [2:0] tx_pos;
	reg [1:0] tx_slot;
	reg fs_int;
	reg skip_pending;
	wire boundary = drive_edge & (tx_pos == POS_LAST);
	wire [1:0] next_slot = (tx_slot == SLOT_LAST) ? 2'h0 : tx_slot + 2'h1;
	wire frame_start = boundary & (next_slot == 2'h0);
	always @(posedge clk) begin
		if (rst) begin
			tx_pos <= POS_LAST;
			tx_slot <= SLOT_LAST;
			fs_int <= 1'b0;
			frame_pulse_out <= 1'b0;
			skip_pending <= 1'b0;
		end else begin
			if (drive_edge) begin
				tx_pos <= (tx_pos == POS_LAST) ? 3'h0 : tx_pos + 3'h1;
				fs_int <= frame_start;
				frame_pulse_out <= frame_start ^ frame_pulse_polarity;
			end
			if (boundary)
				tx_slot <= next_slot;
			if (skip_wr)
				skip_pending <= 1'b1;
			else if (boundary)
				skip_pending <= 1'b0;
		end
	end

	// per transmitter: holding, shifter, frame activity, flag mode
	wire [2:0] pin_o;
	wire [2:0] pin_oe;
	wire [2:0] moved;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_tx
			reg [W-1:0] hold;
			reg full;
			reg [W-1:0] shifter;
			reg active;
			reg flag_mode;
			reg o_r;
			reg oe_r;
			wire act_n = frame_start ? tx_en[gi] : (active & tx_en[gi]);
			wire xfer = act_n & (network_select | frame_start) & ~skip_pending;
			wire flag_n = frame_start ? ~tx_on[gi] : flag_mode;
			assign moved[gi] = boundary & xfer & full;
			// one process per pin bit; the vectors only gather them
			assign pin_o[gi] = o_r;
			assign pin_oe[gi] = oe_r;
			always @(posedge clk) begin
				if (rst) begin
					hold <= {W{1'b0}};
					full <= 1'b0;
					shifter <= {W{1'b0}};
					active <= 1'b0;
					flag_mode <= 1'b0;
					o_r <= 1'b0;
					oe_r <= 1'b0;
				end else begin
					if (boundary) begin
						active <= act_n;
						flag_mode <= flag_n;
						if (xfer) begin
							// underrun sends zeros, never stale holding bits
							shifter <= full ? {hold[W-2:0], 1'b0} : {W{1'b0}};
							o_r <= full & hold[W-1];
							oe_r <= 1'b1;
							full <= 1'b0;
						end else if (gi != 0 && flag_n) begin
							o_r <= flag_bits[gi];
							oe_r <= 1'b1;
						end else begin
							oe_r <= 1'b0;
						end
					end else if (drive_edge) begin
						o_r <= oe_r & active ? shifter[W-1] : o_r;
						shifter <= {shifter[W-2:0], 1'b0};
					end
					// disabled: pending holding data is dropped, never shifted
					if (!tx_en[gi])
						full <= 1'b0;
					if (hold_wr[gi]) begin
						hold <= avs_writedata[W-1:0];
						full <= tx_en[gi];
					end
				end
			end
		end
	endgenerate

	always @(posedge clk) begin
		if (rst) begin
			serial_tx_pin_o <= 1'b0;
			serial_tx_pin_oe <= 1'b0;
			aux_pin_0_o <= 1'b0;
			aux_pin_0_oe <= 1'b0;
			aux_pin_1_o <= 1'b0;
			aux_pin_1_oe <= 1'b0;
		end else begin
			serial_tx_pin_o <= pin_o[0];
			serial_tx_pin_oe <= pin_oe[0];
			aux_pin_0_o <= pin_o[1];
			aux_pin_0_oe <= pin_oe[1];
			aux_pin_1_o <= pin_o[2];
			aux_pin_1_oe <= pin_oe[2];
		end
	end

	// empty flag: a move sets it and wins over a clearing write
	reg [2:0] wr_mask;
	wire [2:0] mask_n = wr_mask | hold_wr;
	wire empty_clr = skip_wr | (|(hold_wr & ~tx_en)) | ((|hold_wr) & ((mask_n & tx_en) == tx_en));
	always @(posedge clk) begin
		if (rst) begin
			tx_empty_flag <= 1'b1;
			wr_mask <= 3'h0;
		end else if (|moved) begin
			tx_empty_flag <= 1'b1;
			wr_mask <= 3'h0;
		end else if (empty_clr) begin
			tx_empty_flag <= 1'b0;
			wr_mask <= 3'h0;
		end else begin
			wr_mask <= mask_n;
		end
	end

	// receiver
	reg [2:0] rx_pos;
	reg [1:0] rx_slot;
	reg rx_busy;
	reg rx_hold_off;
	reg rx_on_prev;
	reg fs_prev;
	reg [W-1:0] rx_sh;
	wire rx_bit = pin_s2[3];
	wire fs_ext = frame_pulse_polarity ? ~pin_s2[2] : pin_s2[2];
	wire fs_now = shared_timing_select ? fs_int : fs_ext;
	wire rx_fstart = fs_now & ~fs_prev;
	wire rx_allow = rx_on & ~rx_hold_off;
	always @(posedge clk) begin
		if (rst) begin
			rx_pos <= 3'h0;
			rx_slot <= 2'h0;
			rx_busy <= 1'b0;
			rx_hold_off <= 1'b0;
			rx_on_prev <= 1'b0;
			fs_prev <= 1'b0;
			rx_sh <= {W{1'b0}};
			rx_data <= {W{1'b0}};
			rx_full <= 1'b0;
		end else begin
			rx_on_prev <= rx_on;
			if (rxd_rd)
				rx_full <= 1'b0;
			if (network_select && rx_on_prev && !rx_on)
				rx_hold_off <= 1'b1;
			if (sample_edge) begin
				fs_prev <= fs_now;
				if (rx_fstart) begin
					rx_hold_off <= 1'b0;
					rx_pos <= 3'h1;
					rx_slot <= 2'h0;
					rx_busy <= rx_allow;
					rx_sh <= {{(W-1){1'b0}}, rx_bit};
				end else if (rx_pos == 3'h0) begin
					// later slots only in network framing, and only inside the frame
					rx_busy <= rx_allow & network_select & (rx_slot != 2'h0);
					rx_pos <= 3'h1;
					rx_sh <= {{(W-1){1'b0}}, rx_bit};
				end else begin
					rx_sh <= {rx_sh[W-2:0], rx_bit};
					if (rx_pos == POS_LAST) begin
						rx_pos <= 3'h0;
						rx_slot <= rx_slot + 2'h1;
						if (rx_busy) begin
							rx_data <= {rx_sh[W-2:0], rx_bit};
							rx_full <= 1'b1;
						end
						rx_busy <= 1'b0;
					end else begin
						rx_pos <= rx_pos + 3'h1;
					end
				end
			end
		end
	end
endmodule

// ===== verif/espc_serial_ctrl_sva.sv
`timescale 1ns/10ps
module espc_chk(
	input wire clk,
	input wire rstn,
	input wire [4:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	input wire tx_bit_clk,
	input wire frame_pulse_out,
	input wire serial_tx_pin_o,
	input wire serial_tx_pin_oe,
	input wire aux_pin_0_o,
	input wire aux_pin_0_oe,
	input wire aux_pin_1_o,
	input wire aux_pin_1_oe
);
	reg [23:0] ctrl;
	reg [9:0] quiet;
	reg [8:0] off;
	wire acc = avs_write && !avs_waitrequest;
	wire fa = frame_pulse_out ^ ctrl[10];
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// shadow of the control word, so pin checks need no body access
	always @(posedge clk) begin
		if (!rstn || (acc && avs_address == 5'h1C && avs_writedata[0]))
			ctrl <= 24'h000000;
		else if (acc && avs_address == 5'h00)
			ctrl <= avs_writedata[23:0];
		quiet <= (!rstn || acc) ? 10'h000 : quiet + {9'h000, ~&quiet};
		off <= (!rstn || ctrl[16]) ? 9'h000 : off + {8'h00, ~&off};
	end
	chk_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	chk_req_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered");
	chk_reset_pins: assert property (disable iff (1'b0) !rstn |=> !serial_tx_pin_oe && !frame_pulse_out)
		else $error("pins active after reset");
	chk_ctrl_read: assert property (avs_read && !avs_waitrequest && avs_address == 5'h00 |-> avs_readdata == {8'h00, ctrl})
		else $error("control readback wrong");
	chk_tx0_release: assert property (&off |-> !serial_tx_pin_oe)
		else $error("data pin still driven");
	chk_drive_edge: assert property ($changed(serial_tx_pin_o) && serial_tx_pin_oe && $past(serial_tx_pin_oe)
		|-> tx_bit_clk == !ctrl[11])
		else $error("data changed on wrong edge");
	chk_frame_start: assert property ($rose(fa) && ctrl == $past(ctrl, 3) |=> fa[*8])
		else $error("frame sync pulse too short");
	chk_flag_pins: assert property (quiet > 10'h2BC |->
		(aux_pin_0_o == ctrl[0] || ctrl[15] && ctrl[12]) && (aux_pin_1_o == ctrl[1] || ctrl[14] && ctrl[12]))
		else $error("flag pin wrong");
	chk_flag_drive: assert property (quiet > 10'h2BC |->
		(aux_pin_0_oe || ctrl[15]) && (aux_pin_1_oe || ctrl[14]))
		else $error("flag pin not driven");
endmodule
bind espc_serial_ctrl espc_chk chk(.clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
	.avs_readdata, .avs_waitrequest, .tx_bit_clk, .frame_pulse_out, .serial_tx_pin_o, .serial_tx_pin_oe,
	.aux_pin_0_o, .aux_pin_0_oe, .aux_pin_1_o, .aux_pin_1_oe);

// ===== verif/espc_codec_model.sv
`timescale 1ns/10ps
module espc_codec_model(
	input wire run,
	input wire tx_d,
	input wire tx_oe,
	output reg bclk,
	output reg rx_d
);
	initial begin
		bclk = 1'b0;
		rx_d = 1'b0;
		forever #80 bclk = run ? ~bclk : bclk;
	end
	// echo what was sent; a released line toggles so no stale level leaks
	always @(bclk) rx_d <= tx_oe ? tx_d : ~rx_d;
endmodule

// ===== verif/serial_port_enable_mode_control_bench.sv
`timescale 1ns/10ps
`include "espc_defs.vh"
module serial_port_enable_mode_control_bench;
	reg clk, rstn, rd_r, wr_r, run, p;
	reg [4:0] adr;
	reg [31:0] wd, rd, v;
	reg [7:0] d;
	wire [31:0] rdata;
	wire wait_r, bclk, rx_d, fs, tx_o, tx_oe;
	integer fail_count, n_compared, i, k, n;
	integer cyc = 0;
	espc_serial_ctrl uut(.clk(clk), .rstn(rstn), .avs_address(adr), .avs_read(rd_r), .avs_write(wr_r),
		.avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdata), .avs_waitrequest(wait_r),
		.tx_bit_clk(bclk), .rx_bit_clk(bclk), .rx_frame_pin(fs), .serial_rx_pin(rx_d), .frame_pulse_out(fs),
		.serial_tx_pin_o(tx_o), .serial_tx_pin_oe(tx_oe), .aux_pin_0_o(), .aux_pin_0_oe(), .aux_pin_1_o(),
		.aux_pin_1_oe());
	espc_codec_model codec(.run(run), .tx_d(tx_o), .tx_oe(tx_oe), .bclk(bclk), .rx_d(rx_d));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 60000) begin
			fail_count = fail_count + 1;
			results;
		end
	end
	task bus(input reg w, input reg [4:0] a, input reg [31:0] x);
		begin
			adr <= a;
			wd <= x;
			wr_r <= w;
			rd_r <= !w;
			do @(posedge clk); while (wait_r !== 1'b0);
			rd = rdata;
			wr_r <= 1'b0;
			rd_r <= 1'b0;
			@(posedge clk);
		end
	endtask
	task cmp(input reg [31:0] got, input reg [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task results;
		begin
			if (fail_count == 0 && n_compared > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	// receive on, tx0 on; edge, framing and separate timing from m
	function [31:0] cw(input integer m);
		cw = (32'h00031000 ^ ({31'h0, m[2]} << 12)) | ({31'h0, m[0]} << 11) | ({31'h0, m[1]} << 13);
	endfunction
	initial begin
		fail_count = 0;
		n_compared = 0;
		rstn = 1'b0;
		rd_r = 1'b0;
		wr_r = 1'b0;
		adr = 5'h00;
		wd = 32'h0;
		run = 1'b0;
		n = $urandom(32'hCCB20AF4);
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		run <= 1'b1;
		@(posedge clk);
		bus(1'b0, `ESPC_OFF_CTRL_B, 32'h0);
		cmp(rd, 32'h0);
		for (i = 0; i < 6; i = i + 1) begin
			v = $urandom & 32'h0002F403;
			bus(1'b1, `ESPC_OFF_CTRL_B, v);
			bus(1'b0, `ESPC_OFF_CTRL_B, 32'h0);
			cmp(rd, v);
		end
		bus(1'b1, `ESPC_OFF_SOFT_RESET, 32'h1);
		bus(1'b0, `ESPC_OFF_CTRL_B, 32'h0);
		cmp(rd, 32'h0);
		// frames must keep coming with every enable clear, both polarities
		for (i = 0; i < 2; i = i + 1) begin
			bus(1'b1, `ESPC_OFF_CTRL_B, (i << 10) | ($urandom & 32'h3));
			k = 0;
			repeat (1400) begin
				p = fs ^ i[0];
				@(posedge clk);
				if (!p && (fs ^ i[0]))
					k = k + 1;
			end
			cmp(k >= 2, 32'h1);
		end
		bus(1'b1, `ESPC_OFF_CTRL_B, 32'h00001000);
		bus(1'b1, `ESPC_OFF_HOLD_0, $urandom & 32'hFF);
		bus(1'b0, `ESPC_OFF_STATUS, 32'h0);
		cmp(rd & 32'h1, 32'h0);
		k = 0;
		repeat (1400) begin
			@(posedge clk);
			k = k + tx_oe;
		end
		cmp(k, 32'h0);
		for (i = 0; i < 5; i = i + 1) begin
			bus(1'b1, `ESPC_OFF_CTRL_B, 32'h0);
			repeat (400) @(posedge clk);
			bus(1'b1, `ESPC_OFF_CTRL_B, cw(i));
			v = $urandom;
			d = v[7:0] | 8'h80;
			bus(1'b1, `ESPC_OFF_HOLD_0, {24'h0, d});
			n = 0;
			while (n < 600 && rd !== {24'h0, d}) begin
				bus(1'b0, `ESPC_OFF_STATUS, 32'h0);
				if (rd[1])
					bus(1'b0, `ESPC_OFF_RX_DATA, 32'h0);
				n = n + 1;
			end
			cmp(rd, {24'h0, d});
		end
		bus(1'b0, `ESPC_OFF_STATUS, 32'h0);
		cmp(rd & 32'h1, 32'h1);
		bus(1'b1, `ESPC_OFF_CTRL_B, 32'h00011000);
		repeat (300) @(posedge clk);
		bus(1'b0, `ESPC_OFF_RX_DATA, 32'h0);
		bus(1'b1, `ESPC_OFF_HOLD_0, 32'hA5);
		repeat (1400) @(posedge clk);
		bus(1'b0, `ESPC_OFF_STATUS, 32'h0);
		cmp(rd & 32'h2, 32'h0);
		results;
	end
endmodule
